//--- design/asa_burst_addr.sv
// Purpose: auto-increment address pointer of the register port
// Assumes: address, step and stop strobes are one-cycle pulses
// Notes: fast mode skips the X and Y low bytes of the sample; the Z low byte still follows Z high
`timescale 1ns/10ps
module asa_burst_addr
    import asa_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic addr_load,
    input wire logic [7:0] addr_in,
    input wire logic step,
    input wire logic fast_read,
    input wire logic stop_det,
    input wire logic four_wire,
    output logic [7:0] addr
);
    import asa_pkg::*;

    logic [7:0] addr_r;
    logic [7:0] addr_nxt;

    // ------------------------------------------------------------
    // next address
    // ------------------------------------------------------------
    always_comb begin
        addr_nxt = addr_r;
        if (stop_det && !four_wire) begin
            addr_nxt = ADDR_RESET; // [RQ15]
        end else if (addr_load) begin
            addr_nxt = addr_in;
        end else if (step) begin
            if (fast_read && (addr_r == ADDR_X_HI || addr_r == ADDR_Y_HI)) begin
                addr_nxt = addr_r + 8'h02; // [RQ2]
            end else begin
                addr_nxt = addr_r + 8'h01; // [RQ2]
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_r <= ADDR_RESET;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    assign addr = addr_r;
endmodule

//--- design/asa_pkg.sv
// Purpose: shared constants for the acceleration status alias block
// Assumes: byte-wide register port, 14-bit acceleration samples
// Notes: none
package asa_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_HI = 8'h01;
    localparam logic [7:0] ADDR_X_LO = 8'h02;
    localparam logic [7:0] ADDR_Y_HI = 8'h03;
    localparam logic [7:0] ADDR_Y_LO = 8'h04;
    localparam logic [7:0] ADDR_Z_HI = 8'h05;
    localparam logic [7:0] ADDR_Z_LO = 8'h06;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int SRS_XYZ_OW_BIT = 7;
    localparam int SRS_AXIS_OW_LSB = 4;
    localparam int SRS_XYZ_DR_BIT = 3;
    localparam int SRS_AXIS_DR_LSB = 0;
    localparam int FLS_OVF_BIT = 7;
    localparam int FLS_WMRK_BIT = 6;
    localparam int FLS_CNT_LSB = 0;
    localparam int FLS_CNT_W = 6;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] CNT_RESET = 6'h00;
    localparam logic [5:0] CNT_MAX = 6'h20;
    localparam int SAMPLE_W = 14;
    // ------------------------------------------------------------
    // fifo operating modes
    // ------------------------------------------------------------
    localparam logic [1:0] FMODE_OFF = 2'h0;
    localparam logic [1:0] FMODE_TRIG = 2'h3;
    // axis indices
    localparam int AX_X = 0;
    localparam int AX_Y = 1;
    localparam int AX_Z = 2;
endpackage

//--- design/asa_status.sv
// Purpose: data-ready / fifo status alias at address zero and sample readout
// Assumes: acquisition strobes and fifo levels come from the sensor core
// Notes: fifo storage and fifo setup live outside this block
//
// How it works
// [RQ1] address zero shows sample-ready layout when fifo mode is zero, else fifo layout
// [RQ2] burst reads step from address zero into sample bytes, 8- and 14-bit modes
// [RQ3] combined overwrite flag sets when a new set lands before previous set retrieved
// [RQ4] combined overwrite flag clears after all three high bytes are read
// [RQ5] axis overwrite flag sets when new acquisition replaces an unread value
// [RQ6] axis overwrite flag clears on a read of that axis high byte
// [RQ7] combined ready sets on any acquisition, clears after all three high bytes read
// [RQ8] axis ready sets on acquisition, clears on read of that axis high byte
// [RQ9] six-bit count field gives stored samples, zero means empty, up to 32
// [RQ10] overflow flag follows the overflow condition, unaffected by reads
// [RQ11] watermark flag holds while count is at or above watermark level
// [RQ12] in trigger mode the watermark flag reports a detected trigger event
// [RQ13] reading fifo status clears fifo interrupt source bit, flags persist
// [RQ14] fifo source bit sets again on next sample entry while a condition holds
// [RQ15] two-wire stop returns pointer to zero; four-wire host must re-address
// [RQ16] status layouts are read-only and all flags and counts reset to zero
`timescale 1ns/10ps
module asa_status
    import asa_pkg::*;
#(
    parameter int SW = asa_pkg::SAMPLE_W
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic active_entry,
    input wire logic [1:0] fifo_mode,
    input wire logic acq_x,
    input wire logic acq_y,
    input wire logic acq_z,
    input wire logic [SW-1:0] sample_x,
    input wire logic [SW-1:0] sample_y,
    input wire logic [SW-1:0] sample_z,
    input wire logic [SW-1:0] fifo_x,
    input wire logic [SW-1:0] fifo_y,
    input wire logic [SW-1:0] fifo_z,
    input wire logic [5:0] fifo_count,
    input wire logic [5:0] fifo_wmrk_level,
    input wire logic fifo_overflow,
    input wire logic fifo_trig_event,
    input wire logic fifo_push,
    input wire logic addr_load,
    input wire logic [7:0] addr_in,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic fast_read,
    input wire logic stop_det,
    input wire logic four_wire,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [7:0] cur_addr,
    output logic src_fifo,
    output logic fifo_pop
);
    import asa_pkg::*;

    logic [2:0] acq;
    logic [2:0] hi_read;
    logic [2:0] dr_r;
    logic [2:0] ow_r;
    logic [2:0] seen_r;
    logic xyz_dr_r;
    logic xyz_ow_r;
    logic all_read;
    logic any_acq;
    logic wmrk_flag;
    logic [5:0] cnt_field;
    logic [7:0] srs_byte;
    logic [7:0] fls_byte;
    logic [7:0] byte_mux;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic src_fifo_r;
    logic fifo_pop_r;
    logic [SW-1:0] sx;
    logic [SW-1:0] sy;
    logic [SW-1:0] sz;
    logic fifo_on;
    logic step;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] hi_byte(input logic [SW-1:0] s);
        logic [15:0] w;
        w = {s, {(16 - SW){1'b0}}};
        return w[15:8];
    endfunction

    function automatic logic [7:0] lo_byte(input logic [SW-1:0] s);
        logic [15:0] w;
        w = {s, {(16 - SW){1'b0}}};
        return w[7:0];
    endfunction

    // ------------------------------------------------------------
    // address pointer
    // ------------------------------------------------------------
    assign step = rd_strobe || wr_strobe;

    asa_burst_addr u_addr (
        .clk(clk),
        .rstn(rstn),
        .addr_load(addr_load),
        .addr_in(addr_in),
        .step(step),
        .fast_read(fast_read),
        .stop_det(stop_det),
        .four_wire(four_wire),
        .addr(cur_addr)
    );

    // ------------------------------------------------------------
    // strobes decode
    // ------------------------------------------------------------
    assign fifo_on = (fifo_mode != FMODE_OFF);
    assign acq = {acq_z, acq_y, acq_x};
    assign any_acq = |acq;
    assign hi_read[AX_X] = rd_strobe && (cur_addr == ADDR_X_HI);
    assign hi_read[AX_Y] = rd_strobe && (cur_addr == ADDR_Y_HI);
    assign hi_read[AX_Z] = rd_strobe && (cur_addr == ADDR_Z_HI);
    assign all_read = &(seen_r | hi_read);

    // ------------------------------------------------------------
    // per-axis ready and overwrite flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dr_r <= 3'h0; // [RQ16]
        end else if (active_entry) begin
            dr_r <= 3'h0; // [RQ16]
        end else begin
            dr_r <= acq | (dr_r & ~hi_read); // [RQ8]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ow_r <= 3'h0; // [RQ16]
        end else if (active_entry) begin
            ow_r <= 3'h0;
        end else begin
            // a read landing with the new sample means the old one was taken
            ow_r <= (acq & dr_r & ~hi_read) | (ow_r & ~hi_read); // [RQ5] [RQ6]
        end
    end

    // ------------------------------------------------------------
    // combined ready and overwrite flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_r <= 3'h0;
        end else if (active_entry || any_acq || all_read) begin
            seen_r <= 3'h0;
        end else begin
            seen_r <= seen_r | hi_read;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xyz_dr_r <= 1'b0;
        end else if (active_entry) begin
            xyz_dr_r <= 1'b0;
        end else if (any_acq) begin
            xyz_dr_r <= 1'b1; // [RQ7]
        end else if (all_read) begin
            xyz_dr_r <= 1'b0; // [RQ7]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xyz_ow_r <= 1'b0;
        end else if (active_entry) begin
            xyz_ow_r <= 1'b0;
        end else if (any_acq && xyz_dr_r && !all_read) begin
            xyz_ow_r <= 1'b1; // [RQ3]
        end else if (all_read) begin
            xyz_ow_r <= 1'b0; // [RQ4]
        end
    end

    // ------------------------------------------------------------
    // fifo status fields
    // ------------------------------------------------------------
    assign cnt_field = (fifo_count > CNT_MAX) ? CNT_MAX : fifo_count; // [RQ9]
    always_comb begin
        if (fifo_mode == FMODE_TRIG) begin
            wmrk_flag = fifo_trig_event; // [RQ12]
        end else begin
            wmrk_flag = (cnt_field >= fifo_wmrk_level); // [RQ11]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_fifo_r <= 1'b0; // [RQ16]
        end else if (active_entry) begin
            src_fifo_r <= 1'b0;
        end else if (fifo_push && (fifo_overflow || wmrk_flag)) begin
            src_fifo_r <= 1'b1; // [RQ14]
        end else if (rd_strobe && fifo_on && cur_addr == ADDR_STATUS) begin
            src_fifo_r <= 1'b0; // [RQ13]
        end
    end

    // ------------------------------------------------------------
    // status layouts and read mux
    // ------------------------------------------------------------
    always_comb begin
        srs_byte = STATUS_RESET;
        srs_byte[SRS_XYZ_OW_BIT] = xyz_ow_r;
        srs_byte[SRS_AXIS_OW_LSB +: 3] = ow_r;
        srs_byte[SRS_XYZ_DR_BIT] = xyz_dr_r;
        srs_byte[SRS_AXIS_DR_LSB +: 3] = dr_r;
        fls_byte = STATUS_RESET;
        fls_byte[FLS_OVF_BIT] = fifo_overflow; // [RQ10]
        fls_byte[FLS_WMRK_BIT] = wmrk_flag;
        fls_byte[FLS_CNT_LSB +: FLS_CNT_W] = cnt_field;
    end

    assign sx = fifo_on ? fifo_x : sample_x;
    assign sy = fifo_on ? fifo_y : sample_y;
    assign sz = fifo_on ? fifo_z : sample_z;

    always_comb begin
        case (cur_addr)
            ADDR_STATUS: byte_mux = fifo_on ? fls_byte : srs_byte; // [RQ1]
            ADDR_X_HI: byte_mux = hi_byte(sx); // [RQ2]
            ADDR_X_LO: byte_mux = lo_byte(sx);
            ADDR_Y_HI: byte_mux = hi_byte(sy);
            ADDR_Y_LO: byte_mux = lo_byte(sy);
            ADDR_Z_HI: byte_mux = hi_byte(sz);
            ADDR_Z_LO: byte_mux = lo_byte(sz);
            default: byte_mux = STATUS_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // read data register; writes change nothing here
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= STATUS_RESET;
        end else if (rd_strobe) begin
            rd_data_r <= byte_mux;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_strobe;
        end
    end

    // ------------------------------------------------------------
    // fifo head advance after Z low byte read, or Z high byte read in fast mode
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fifo_pop_r <= 1'b0;
        end else begin
            fifo_pop_r <= rd_strobe && fifo_on && (cnt_field != CNT_RESET)
                && (cur_addr == (fast_read ? ADDR_Z_HI : ADDR_Z_LO));
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign src_fifo = src_fifo_r;
    assign fifo_pop = fifo_pop_r;
endmodule

//--- testbench/asa_host.sv
// Purpose: host controller model on the register port
// Assumes: strobes are one-cycle pulses
// Notes: read data taken while rd_valid stands
`timescale 1ns/10ps
module asa_host (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic addr_load,
    output logic [7:0] addr_in,
    output logic rd_strobe,
    output logic wr_strobe,
    output logic [7:0] wr_data,
    output logic stop_det
);
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    initial begin
        {addr_load, rd_strobe, wr_strobe, stop_det} = 4'h0;
        {addr_in, wr_data} = 16'h0000;
    end
    // explicit re-address, needed in four-wire mode
    task automatic set_addr(input logic [7:0] a);
        @(posedge clk) {addr_load, addr_in} <= {1'b1, a};
        @(posedge clk) {addr_load, addr_in} <= {1'b0, ~a};
    endtask
    task automatic rd(output logic [7:0] d);
        @(posedge clk) rd_strobe <= 1'b1;
        @(posedge clk) rd_strobe <= 1'b0;
        @(negedge clk) d = rd_valid ? rd_data : 8'hxx;
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge clk) {wr_strobe, wr_data} <= {1'b1, v};
        @(posedge clk) {wr_strobe, wr_data} <= {1'b0, ~v};
    endtask
    task automatic send_stop();
        @(posedge clk) stop_det <= 1'b1;
        @(posedge clk) stop_det <= 1'b0;
    endtask
endmodule

//--- testbench/asa_status_bench.sv
// Purpose: self-checking bench for asa_status
// Assumes: host model drives the register port
// Notes: fifo head samples held constant
`timescale 1ns/10ps
module asa_status_bench;
    import asa_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] pl = 5'h00;
    logic fifo_overflow = 1'b0, fifo_trig_event = 1'b0, fast_read = 1'b0, four_wire = 1'b0;
    logic [1:0] fifo_mode = 2'h0;
    logic [5:0] fifo_count = 6'h00, fifo_wmrk_level = 6'h00;
    logic [13:0] sample_x = 14'h2a5c, sample_y = 14'h0f31, sample_z = 14'h3c07;
    logic [13:0] fifo_x = 14'h1b3d, fifo_y = 14'h0456, fifo_z = 14'h2d71;
    logic addr_load, rd_strobe, wr_strobe, stop_det, rd_valid, src_fifo, fifo_pop;
    logic [7:0] addr_in, wr_data, rd_data, cur_addr, d;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    asa_status dut (.clk(clk), .rstn(rstn), .active_entry(pl[4]), .fifo_mode(fifo_mode), .acq_x(pl[0]),
        .acq_y(pl[1]), .acq_z(pl[2]), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
        .fifo_x(fifo_x), .fifo_y(fifo_y), .fifo_z(fifo_z), .fifo_count(fifo_count),
        .fifo_wmrk_level(fifo_wmrk_level), .fifo_overflow(fifo_overflow), .fifo_trig_event(fifo_trig_event),
        .fifo_push(pl[3]), .addr_load(addr_load), .addr_in(addr_in), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .fast_read(fast_read), .stop_det(stop_det),
        .four_wire(four_wire), .rd_data(rd_data), .rd_valid(rd_valid), .cur_addr(cur_addr),
        .src_fifo(src_fifo), .fifo_pop(fifo_pop));
    asa_host host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .addr_load(addr_load),
        .addr_in(addr_in), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data), .stop_det(stop_det));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge clk) pl <= m;
        @(posedge clk) pl <= 5'h00;
    endtask
    task automatic st(input logic [7:0] exp);
        host.set_addr(ADDR_STATUS);
        host.rd(d);
        chk(d, exp);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        st(8'h00);
        host.set_addr(ADDR_STATUS);
        host.wr(8'hff);
        st(8'h00);
        pulse(5'h01);
        pulse(5'h10);
        st(8'h00);
    endtask
    task automatic t_axis();
        pulse(5'h01);
        st(8'h09);
        pulse(5'h01);
        st(8'h99);
        pulse(5'h02);
        host.set_addr(ADDR_X_HI);
        host.rd(d);
        st(8'h8a);
        host.set_addr(ADDR_Y_HI);
        host.rd(d);
        host.set_addr(ADDR_Z_HI);
        host.rd(d);
        st(8'h00);
    endtask
    task automatic t_burst(input logic fr);
        logic [7:0] e [7];
        @(posedge clk) {fast_read, sample_x, sample_y} <= {fr, sample_x ^ 14'h2aaa, sample_y + 14'h0123};
        pulse(5'h07);
        e = '{8'h0f, sample_x[13:6], {sample_x[5:0], 2'b00}, sample_y[13:6], {sample_y[5:0], 2'b00},
            sample_z[13:6], {sample_z[5:0], 2'b00}};
        host.set_addr(ADDR_STATUS);
        for (int i = 0; i < 7; i++) begin
            if (fr && (i == 2 || i == 4)) continue;
            host.rd(d);
            chk(d, e[i]);
        end
        chk_flag(fifo_pop, 1'b0);
        host.rd(d);
        chk(d, 8'h00);
        @(posedge clk) fast_read <= 1'b0;
    endtask
    task automatic t_fifo();
        @(posedge clk) {fifo_mode, fifo_count, fifo_wmrk_level, fifo_overflow} <= {2'h1, 6'h20, 6'h20, 1'b1};
        st(8'he0);
        host.rd(d);
        chk(d, fifo_x[13:6]);
        repeat (5) host.rd(d);
        chk(d, {fifo_z[5:0], 2'b00});
        chk_flag(fifo_pop, 1'b1);
        st(8'he0);
        @(posedge clk) fifo_count <= 6'h1f;
        st(8'h9f);
        for (int m = 1; m < 4; m++) begin
            @(posedge clk) {fifo_mode, fifo_count, fifo_wmrk_level, fifo_overflow, fifo_trig_event} <=
                {m[1:0], 6'h05, 6'h10, 1'b0, 1'b1};
            st((m == 3) ? 8'h45 : 8'h05);
        end
    endtask
    task automatic t_src();
        @(posedge clk) {fifo_mode, fifo_overflow} <= {2'h1, 1'b1};
        pulse(5'h08);
        @(negedge clk) chk_flag(src_fifo, 1'b1);
        st(8'h85);
        chk_flag(src_fifo, 1'b0);
        pulse(5'h08);
        @(negedge clk) chk_flag(src_fifo, 1'b1);
        @(posedge clk) fifo_overflow <= 1'b0;
        st(8'h05);
        pulse(5'h08);
        @(negedge clk) chk_flag(src_fifo, 1'b0);
        @(posedge clk) fifo_mode <= 2'h0;
    endtask
    task automatic t_stop();
        host.set_addr(ADDR_STATUS);
        host.rd(d);
        host.rd(d);
        chk(cur_addr, 8'h02);
        host.send_stop();
        @(negedge clk) chk(cur_addr, 8'h00);
        @(posedge clk) four_wire <= 1'b1;
        host.set_addr(ADDR_Y_HI);
        host.send_stop();
        @(negedge clk) chk(cur_addr, ADDR_Y_HI);
        @(posedge clk) four_wire <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_axis();
        t_burst(1'b0);
        t_burst(1'b1);
        t_fifo();
        t_src();
        t_stop();
        stop_test();
    end
endmodule

//--- testbench/asa_status_checker.sv
// Purpose: port assertions for asa_status
// Assumes: one clock, async active-low reset
// Notes: bound to every asa_status instance
`timescale 1ns/10ps
module asa_status_checker
    import asa_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic active_entry,
    input wire logic [1:0] fifo_mode,
    input wire logic acq_x,
    input wire logic [5:0] fifo_count,
    input wire logic [5:0] fifo_wmrk_level,
    input wire logic fifo_overflow,
    input wire logic fifo_trig_event,
    input wire logic fifo_push,
    input wire logic addr_load,
    input wire logic rd_strobe,
    input wire logic fast_read,
    input wire logic stop_det,
    input wire logic four_wire,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [7:0] cur_addr,
    input wire logic src_fifo
);
    import asa_pkg::*;

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    logic [5:0] cnt_exp;
    logic st_rd;
    assign cnt_exp = (fifo_count > CNT_MAX) ? CNT_MAX : fifo_count;
    assign st_rd = rd_strobe && cur_addr == 8'h00;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_reset_clear: assert property (!$past(rstn) |-> cur_addr == 8'h00 && !src_fifo && !rd_valid)
        else $error("outputs not clear after reset");
    chk_read_answer: assert property (rd_strobe |=> rd_valid)
        else $error("read not answered next cycle");
    chk_ptr_step: assert property (rd_strobe && !addr_load && !stop_det && !fast_read && !active_entry
        && cur_addr < 8'h06 |=> cur_addr == $past(cur_addr) + 8'h01) else $error("pointer did not step");
    chk_fifo_layout: assert property (st_rd && fifo_mode != FMODE_OFF
        |=> rd_data[7] == $past(fifo_overflow) && rd_data[5:0] == $past(cnt_exp)) else $error("fifo layout wrong");
    chk_wmrk_level: assert property (st_rd && (fifo_mode == 2'h1 || fifo_mode == 2'h2)
        |=> rd_data[6] == ($past(cnt_exp) >= $past(fifo_wmrk_level))) else $error("watermark flag wrong");
    chk_trig_flag: assert property (st_rd && fifo_mode == FMODE_TRIG
        |=> rd_data[6] == $past(fifo_trig_event)) else $error("trigger flag wrong");
    chk_src_clear: assert property (st_rd && fifo_mode != FMODE_OFF && !fifo_push |=> !src_fifo)
        else $error("fifo source not cleared by read");
    chk_src_set: assert property (fifo_push && fifo_overflow && !active_entry |=> src_fifo)
        else $error("fifo source not set on push");
    chk_stop_home: assert property (stop_det && !four_wire |=> cur_addr == 8'h00)
        else $error("stop did not home pointer");
    chk_ready_set: assert property ((acq_x && !active_entry)
        ##1 (!active_entry && !(rd_strobe && cur_addr == 8'h01))[*3]
        ##1 (st_rd && fifo_mode == FMODE_OFF && !active_entry) |=> rd_data[0] && rd_data[3])
        else $error("ready flags not set");
endmodule

bind asa_status asa_status_checker u_chk (
    .clk(clk),
    .rstn(rstn),
    .active_entry(active_entry),
    .fifo_mode(fifo_mode),
    .acq_x(acq_x),
    .fifo_count(fifo_count),
    .fifo_wmrk_level(fifo_wmrk_level),
    .fifo_overflow(fifo_overflow),
    .fifo_trig_event(fifo_trig_event),
    .fifo_push(fifo_push),
    .addr_load(addr_load),
    .rd_strobe(rd_strobe),
    .fast_read(fast_read),
    .stop_det(stop_det),
    .four_wire(four_wire),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cur_addr(cur_addr),
    .src_fifo(src_fifo)
);
